// ===== sfcf_params.svh
// Constants for the serial flash command front end
`ifndef SFCF_PARAMS_SVH
`define SFCF_PARAMS_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SFCF_OP_WRSR   8'h01
`define SFCF_OP_PP     8'h02
`define SFCF_OP_WRDI   8'h04
`define SFCF_OP_RDSR1  8'h05
`define SFCF_OP_WREN   8'h06
`define SFCF_OP_SE4    8'h20
`define SFCF_OP_QPP    8'h32
`define SFCF_OP_RDSR2  8'h35
`define SFCF_OP_VWREN  8'h50
`define SFCF_OP_BE32   8'h52
`define SFCF_OP_CE2    8'h60
`define SFCF_OP_SUSP   8'h75
`define SFCF_OP_RESM   8'h7a
`define SFCF_OP_RPD    8'hab
`define SFCF_OP_PDN    8'hb9
`define SFCF_OP_CE1    8'hc7
`define SFCF_OP_BE64   8'hd8

// ----------------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------------
`define SFCF_ST_BUSY   0
`define SFCF_ST_WL     1
`define SFCF_ST_BP_LO  2
`define SFCF_ST_BP_HI  4
`define SFCF_ST_TB     5
`define SFCF_ST_SEC    6
`define SFCF_ST_SRP1   8
`define SFCF_ST_CMP    14
`define SFCF_ST_SUS    15
`define SFCF_ST_WMASK  16'h7ffc
`define SFCF_ST_OTP    16'h3c00
`define SFCF_ST_RST    16'h0000

// ----------------------------------------------------------------------
// Array geometry (byte addresses, 21 bits to hold the full size)
// ----------------------------------------------------------------------
`define SFCF_ARR_SZ    21'h100000
`define SFCF_ARR_TOP   21'h0fffff
`define SFCF_BLK_SZ    21'h010000
`define SFCF_SEC_SZ    21'h001000
`define SFCF_HALF_SZ   21'h008000
`define SFCF_M_PAGE    20'h000ff
`define SFCF_M_4K      20'h00fff
`define SFCF_M_32K     20'h07fff
`define SFCF_M_64K     20'h0ffff
`define SFCF_M_CHIP    20'hfffff

// ----------------------------------------------------------------------
// Bit counts within one instruction
// ----------------------------------------------------------------------
`define SFCF_BITS_OP   12'd8
`define SFCF_BITS_ST2  12'd16
`define SFCF_BITS_ST3  12'd24
`define SFCF_BITS_ADR  12'd32
`define SFCF_BITS_MAX  12'hff8
`define SFCF_NIB_STEP  12'd4

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SFCF_REG_STAT  4'h0
`define SFCF_REG_CMD   4'h4
`define SFCF_REG_CTRL  4'h8
`define SFCF_CTRL_DONE 0

`endif

// ===== sfcf_pkg.sv
// Types for the serial flash command front end
package sfcf_pkg;
   // Instruction phase, Gray coded along idle-op-addr-data
   typedef enum logic [1:0] {
      sfcf_ph_idle = 2'b00,
      sfcf_ph_op   = 2'b01,
      sfcf_ph_addr = 2'b11,
      sfcf_ph_data = 2'b10
   } sfcf_phase_t;
endpackage

// ===== sfcf_fifo.sv
// Program data FIFO with registered output stage
`timescale 1ns/1ps
module sfcf_fifo #(
   parameter int W = 9,
   parameter int D = 16
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(D);
   // ----------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------
   logic [W-1:0] mem [D];      // Entry array
   logic [AW-1:0] wr_ptr;      // Next write slot
   logic [AW-1:0] rd_ptr;      // Next read slot
   logic [AW:0] count;         // Entries held in the array
   logic push;
   logic pop;

   assign in_ready_o = (count != D[AW:0]);
   assign push = in_valid_i & in_ready_o;
   // Refill output stage when empty or being drained
   assign pop = (count != '0) & (~out_valid_o | out_ready_i);

   // Array write
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

   // Output register stage
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem[rd_ptr];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule

// ===== sfcf_core.sv
// Serial flash instruction framing and write protection front end
//
// Operation
// (R1) Select falling starts; first byte is opcode
// (R2) Input sampled on clock rise, MSB first
// (R3) Select rising completes or ends instruction
// (R4) Reads may end after any bit
// (R5) Writes ended mid-byte are discarded
// (R6) While busy, only status reads accepted; code also accepts 75h suspend
// (R7) Protected-region erase or program is ignored
// (R8) Complement mode inverts protected region table
// (R9) 05h/35h return status bytes, repeating
// (R10) Read-back bytes driven MSB first
// (R11) Quad program data: high nibble first
// (R12) 75h suspends running erase or program
// (R13) 7Ah resumes suspended erase or program
// (R14) Host may send FFh FFh to exit
// (R15) Decode status write, program, erase, power-down
// (R16) Write latch needed before any modify
// (R17) 50h allows volatile status write
// (R18) Granularity and top-bottom shape the region
// (R19) Complement bit reverses protected area
`timescale 1ns/1ps
`include "sfcf_params.svh"
module sfcf_core #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic sel_n_i,
   input wire logic sclk_i,
   input wire logic serial_in_line_i,
   input wire logic quad_line_one_i,
   output logic quad_line_one_o,
   output logic quad_line_one_oe_o,
   input wire logic quad_line_two_i,
   input wire logic quad_line_three_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic cmd_valid_o,
   output logic [7:0] cmd_op_o,
   output logic [23:0] cmd_addr_o,
   output logic [8:0] prog_data_o,
   output logic prog_valid_o,
   input wire logic prog_ready_i
);
   import sfcf_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] pin_raw;       // Raw link pins
   logic [5:0] sync_a;        // First stage, read only by second
   logic [5:0] sync_b;        // Second stage, safe to use
   logic sclk_d;              // Delayed clock for edge finding
   logic sel_d;               // Delayed select for edge finding

   assign pin_raw = {sel_n_i, sclk_i, quad_line_three_i,
                     quad_line_two_i, quad_line_one_i, serial_in_line_i};

   // Two flops per pin
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_sync
         always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
               // Link clock idles low, the other pins high
               sync_a[gi] <= (gi != 4);
               sync_b[gi] <= (gi != 4);
            end else begin
               sync_a[gi] <= pin_raw[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   // Edge history
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sclk_d <= 1'b0;
         sel_d <= 1'b1;
      end else begin
         sclk_d <= sync_b[4];
         sel_d <= sync_b[5];
      end
   end

   logic sel_n_s;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_fall;
   logic sel_rise;
   assign sel_n_s = sync_b[5];
   assign sclk_rise = sync_b[4] & ~sclk_d & ~sel_n_s;
   assign sclk_fall = ~sync_b[4] & sclk_d & ~sel_n_s;
   assign sel_fall = ~sel_n_s & sel_d;
   assign sel_rise = sel_n_s & ~sel_d;

   // ----------------------------------------------------------------
   // Instruction state
   // ----------------------------------------------------------------
   sfcf_phase_t phase;        // Where in the instruction we are
   logic [11:0] bit_cnt;      // Bits clocked in, saturating
   logic [7:0] shreg;         // Input shift register
   logic [7:0] opcode;        // Captured opcode
   logic [23:0] addr;         // Address or status bytes
   logic ignore;              // Instruction refused at opcode
   logic quad_ph;             // Nibble-wide data phase
   logic [11:0] next_cnt;
   logic [7:0] next_shreg;
   logic byte_done;

   assign quad_ph = (phase == sfcf_ph_data) && (opcode == `SFCF_OP_QPP);

   // Next shift value: one bit, or a nibble in quad data phase
   always_comb begin
      if (quad_ph) begin
         next_shreg = {shreg[3:0], sync_b[3:0]}; // R11
         next_cnt = bit_cnt + `SFCF_NIB_STEP;
      end else begin
         next_shreg = {shreg[6:0], sync_b[0]}; // R2
         next_cnt = bit_cnt + 12'd1;
      end
      if (bit_cnt >= `SFCF_BITS_MAX) begin
         next_cnt = bit_cnt;
      end
   end
   assign byte_done = sclk_rise && (next_cnt[2:0] == 3'h0);

   // ----------------------------------------------------------------
   // Status and control state
   // ----------------------------------------------------------------
   logic [15:0] stat_w;       // Writable status bits
   logic busy;                // Internal cycle running
   logic wl;                  // write_latch
   logic sus;                 // Suspended cycle
   logic susp_ok;             // Running cycle may be suspended
   logic vol_en;              // Next status write is volatile
   logic pdown;               // Powered down
   logic [15:0] status;

   always_comb begin
      status = stat_w & `SFCF_ST_WMASK;
      status[`SFCF_ST_BUSY] = busy;
      status[`SFCF_ST_WL] = wl;
      status[`SFCF_ST_SUS] = sus;
   end

   // Shift engine, phase and opcode capture
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         phase <= sfcf_ph_idle;
         bit_cnt <= '0;
         shreg <= '0;
         opcode <= '0;
         addr <= '0;
         ignore <= 1'b0;
      end else if (sel_rise) begin
         phase <= sfcf_ph_idle; // R3
         bit_cnt <= '0;
      end else if (sel_fall) begin
         phase <= sfcf_ph_op; // R1
         bit_cnt <= '0;
         ignore <= 1'b0;
      end else if (sclk_rise && phase != sfcf_ph_idle) begin
         bit_cnt <= next_cnt;
         shreg <= next_shreg;
         if (byte_done && phase == sfcf_ph_op) begin
            opcode <= next_shreg; // R1
            phase <= sfcf_ph_addr;
            // Busy allows only status reads and suspend
            ignore <= (busy && next_shreg != `SFCF_OP_RDSR1 &&
                       next_shreg != `SFCF_OP_RDSR2 &&
                       next_shreg != `SFCF_OP_SUSP) || // R6
                      (pdown && next_shreg != `SFCF_OP_RPD);
         end else if (byte_done && phase == sfcf_ph_addr) begin
            addr <= {addr[15:0], next_shreg};
            if (next_cnt == `SFCF_BITS_ADR) begin
               phase <= sfcf_ph_data;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Protection decode
   // ----------------------------------------------------------------
   // True when [lo,hi] overlaps any protected byte
   function automatic logic prot_hit(input logic [15:0] st,
                                     input logic [19:0] lo,
                                     input logic [19:0] hi);
      logic [2:0] bp;
      logic [20:0] sz;
      logic none;
      logic all;
      logic pnone;
      logic [20:0] plo;
      logic [20:0] phi;
      begin
         bp = st[`SFCF_ST_BP_HI:`SFCF_ST_BP_LO];
         sz = '0;
         none = (bp == 3'h0);
         all = 1'b0;
         // Granularity picks block or sector sizes
         if (!st[`SFCF_ST_SEC]) begin
            if (bp[2] && bp != 3'h4) begin
               all = 1'b1; // R18
            end else begin
               sz = `SFCF_BLK_SZ << (bp - 3'h1); // R18
            end
         end else if (bp == 3'h7) begin
            all = 1'b1;
         end else if (bp[2]) begin
            sz = `SFCF_HALF_SZ;
         end else begin
            sz = `SFCF_SEC_SZ << (bp - 3'h1); // R18
         end
         // Top or bottom placement
         if (all) begin
            plo = '0;
            phi = `SFCF_ARR_TOP;
         end else if (st[`SFCF_ST_TB]) begin
            plo = '0;
            phi = sz - 21'h1; // R18
         end else begin
            plo = `SFCF_ARR_SZ - sz;
            phi = `SFCF_ARR_TOP;
         end
         pnone = none;
         // Complement reverses the region
         if (st[`SFCF_ST_CMP]) begin
            if (none) begin
               pnone = 1'b0; // R8
               plo = '0;
               phi = `SFCF_ARR_TOP;
            end else if (all) begin
               pnone = 1'b1; // R8
            end else if (st[`SFCF_ST_TB]) begin
               plo = sz; // R19
               phi = `SFCF_ARR_TOP;
            end else begin
               phi = `SFCF_ARR_SZ - sz - 21'h1; // R19
               plo = '0;
            end
         end
         prot_hit = !pnone && ({1'b0, lo} <= phi) && ({1'b0, hi} >= plo);
      end
   endfunction

   logic [19:0] reg_mask;     // Span of the addressed region
   logic is_prog;
   logic is_erase;
   logic hit;

   // Region span per command
   always_comb begin
      is_prog = (opcode == `SFCF_OP_PP) || (opcode == `SFCF_OP_QPP);
      is_erase = 1'b1;
      case (opcode)
         `SFCF_OP_SE4: reg_mask = `SFCF_M_4K;
         `SFCF_OP_BE32: reg_mask = `SFCF_M_32K;
         `SFCF_OP_BE64: reg_mask = `SFCF_M_64K;
         `SFCF_OP_CE1, `SFCF_OP_CE2: reg_mask = `SFCF_M_CHIP;
         default: begin
            reg_mask = `SFCF_M_PAGE;
            is_erase = 1'b0;
         end
      endcase
   end
   assign hit = prot_hit(stat_w, addr[19:0] & ~reg_mask,
                         addr[19:0] | reg_mask); // R7

   // ----------------------------------------------------------------
   // Completion decode at select rising
   // ----------------------------------------------------------------
   logic take;                // Accepted instruction ends now
   logic aligned;             // Whole bytes only
   logic commit;              // Array command goes out
   logic overrun;             // Data lost to back-pressure
   logic chip_er;
   logic addr_ok;

   assign take = sel_rise && phase != sfcf_ph_idle && !ignore;
   assign aligned = (bit_cnt[2:0] == 3'h0); // R5
   assign chip_er = (opcode == `SFCF_OP_CE1) || (opcode == `SFCF_OP_CE2);
   assign addr_ok = chip_er ? (bit_cnt == `SFCF_BITS_OP) :
                    is_prog ? (bit_cnt > `SFCF_BITS_ADR) :
                    (bit_cnt == `SFCF_BITS_ADR);
   assign commit = take && aligned && wl && addr_ok && !hit && // R16
                   (is_prog || is_erase) && !(is_prog && overrun); // R15

   // Status, latch, suspend, power-down and busy
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         stat_w <= `SFCF_ST_RST;
         busy <= 1'b0;
         wl <= 1'b0;
         sus <= 1'b0;
         susp_ok <= 1'b0;
         vol_en <= 1'b0;
         pdown <= 1'b0;
      end else begin
         // Software ends the internal cycle
         if (reg_wr_i && reg_addr_i == `SFCF_REG_CTRL &&
             reg_wdata_i[`SFCF_CTRL_DONE]) begin
            busy <= 1'b0;
            wl <= 1'b0;
         end
         if (take && aligned) begin
            vol_en <= 1'b0;
            case (opcode)
               `SFCF_OP_WREN: wl <= 1'b1; // R16
               `SFCF_OP_WRDI: wl <= 1'b0;
               `SFCF_OP_VWREN: vol_en <= 1'b1; // R17
               `SFCF_OP_WRSR: begin
                  if ((wl || vol_en) && !stat_w[`SFCF_ST_SRP1] &&
                      bit_cnt >= `SFCF_BITS_ST2) begin // R15
                     stat_w[7:0] <= (bit_cnt == `SFCF_BITS_ST2) ?
                                    addr[7:0] : addr[15:8];
                     if (bit_cnt >= `SFCF_BITS_ST3) begin
                        stat_w[15:8] <= addr[7:0] |
                                        (stat_w[15:8] & 8'h3c); // OTP
                     end
                     busy <= !vol_en; // R17
                     susp_ok <= 1'b0;
                     wl <= 1'b0;
                  end
               end
               `SFCF_OP_SUSP: begin
                  if (busy && susp_ok) begin
                     sus <= 1'b1; // R12
                     busy <= 1'b0;
                  end
               end
               `SFCF_OP_RESM: begin
                  if (sus) begin
                     sus <= 1'b0; // R13
                     busy <= 1'b1;
                  end
               end
               `SFCF_OP_PDN: pdown <= 1'b1; // R15
               `SFCF_OP_RPD: pdown <= 1'b0;
               default: begin
                  if (commit) begin
                     busy <= 1'b1;
                     susp_ok <= 1'b1;
                     wl <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   // Command output and record
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cmd_valid_o <= 1'b0;
         cmd_op_o <= '0;
         cmd_addr_o <= '0;
      end else begin
         cmd_valid_o <= commit;
         if (commit) begin
            cmd_op_o <= opcode;
            cmd_addr_o <= chip_er ? 24'h000000 : addr;
         end
      end
   end

   // ----------------------------------------------------------------
   // Program data staging into the FIFO
   // ----------------------------------------------------------------
   logic pend_v;              // Data byte waiting for FIFO
   logic [7:0] pend_d;
   logic term_v;              // End marker waiting for FIFO
   logic term_ok;             // Marker says commit
   logic fifo_in_ready;
   logic fifo_push;
   logic [8:0] fifo_in;
   logic data_byte;

   assign data_byte = byte_done && phase == sfcf_ph_data && is_prog &&
                      !ignore && !sel_rise && !sel_fall;
   assign fifo_push = pend_v | term_v;
   assign fifo_in = pend_v ? {1'b0, pend_d} : {1'b1, 7'h00, term_ok};

   // Pending byte, marker and overrun tracking
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pend_v <= 1'b0;
         pend_d <= '0;
         term_v <= 1'b0;
         term_ok <= 1'b0;
         overrun <= 1'b0;
      end else begin
         if (pend_v && fifo_in_ready) begin
            pend_v <= 1'b0;
         end else if (term_v && fifo_in_ready) begin
            term_v <= 1'b0;
         end
         if (data_byte) begin
            if (pend_v && !fifo_in_ready) begin
               overrun <= 1'b1; // Stalled sink lost a byte
            end else begin
               pend_v <= 1'b1;
               pend_d <= next_shreg;
            end
         end
         if (sel_fall) begin
            overrun <= 1'b0;
         end
         // Marker tells the array side keep or drop
         if (sel_rise && is_prog && phase == sfcf_ph_data && !ignore) begin
            term_v <= 1'b1;
            term_ok <= commit; // R5
         end
      end
   end

   sfcf_fifo #(
      .W(9),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .in_data_i(fifo_in),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .out_data_o(prog_data_o),
      .out_valid_o(prog_valid_o),
      .out_ready_i(prog_ready_i)
   );

   // ----------------------------------------------------------------
   // Status read-back on the output line
   // ----------------------------------------------------------------
   logic rd_active;           // Status read in its data phase
   logic [2:0] out_cnt;       // Bit within outgoing byte
   logic [6:0] out_sh;        // Remaining bits of outgoing byte
   logic [7:0] out_byte;

   assign rd_active = !sel_n_s && bit_cnt >= `SFCF_BITS_OP && !ignore &&
                      (opcode == `SFCF_OP_RDSR1 || opcode == `SFCF_OP_RDSR2);
   assign out_byte = (opcode == `SFCF_OP_RDSR2) ? status[15:8] :
                     status[7:0]; // R9

   // Drive on falling clock, byte reloaded each time round
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         quad_line_one_o <= 1'b0;
         quad_line_one_oe_o <= 1'b0;
         out_cnt <= '0;
         out_sh <= '0;
      end else if (!rd_active) begin
         quad_line_one_oe_o <= 1'b0; // R4
         out_cnt <= '0;
      end else begin
         quad_line_one_oe_o <= 1'b1;
         if (sclk_fall) begin
            out_cnt <= out_cnt + 3'h1;
            if (out_cnt == 3'h0) begin
               quad_line_one_o <= out_byte[7]; // R10
               out_sh <= out_byte[6:0];
            end else begin
               quad_line_one_o <= out_sh[6]; // R9
               out_sh <= {out_sh[5:0], 1'b0};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `SFCF_REG_STAT: reg_rdata_o <= {16'h0000, status};
            `SFCF_REG_CMD: reg_rdata_o <= {cmd_op_o, cmd_addr_o};
            default: reg_rdata_o <= '0;
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end
endmodule

// ===== sfcf_end_marker_note.sv
`timescale 1ns/1ps

// ===== sfcf_core_asserts.sv
// Port checks of the flash command front end
`timescale 1ns/1ps
module sfcf_chk (
   input wire logic sys_clk_i, srst_i, sel_n_i, reg_rd_i, cmd_valid_o,
   input wire logic quad_line_one_oe_o, prog_valid_o, prog_ready_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [7:0] cmd_op_o,
   input wire logic [23:0] cmd_addr_o,
   input wire logic [8:0] prog_data_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   // Select held inactive long enough for the sync
   sequence s_sel_idle;
      sel_n_i [*8];
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0)
      else $error("read data outside read slot");
   a_cmd_single: assert property (cmd_valid_o |=> !cmd_valid_o)
      else $error("command pulse too long");
   a_cmd_at_end: assert property (cmd_valid_o |-> sel_n_i)
      else $error("command while selected");
   a_op_hold: assert property ($changed(cmd_op_o) |-> cmd_valid_o)
      else $error("opcode moved without command");
   a_addr_hold: assert property ($changed(cmd_addr_o) |-> cmd_valid_o)
      else $error("address moved without command");
   a_oe_start: assert property ($rose(quad_line_one_oe_o)
      |-> $past(sel_n_i, 3) == 1'b0)
      else $error("output enabled while deselected");
   a_oe_end: assert property (s_sel_idle |-> !quad_line_one_oe_o)
      else $error("output still driven");
   a_prog_hold: assert property (prog_valid_o && !prog_ready_i
      |=> prog_valid_o && $stable(prog_data_o))
      else $error("program data lost under stall");
endmodule
bind sfcf_core sfcf_chk chk (.*);

// ===== sfcf_host.sv
// Host model driving the serial link of the front end
`timescale 1ns/1ps
module sfcf_host (
   output logic sel_n, sclk, d0,
   output wire logic d2, d3,
   input wire logic d1
);
   logic [15:0] rx; // Bits read back, newest last
   assign d2 = ~d0;
   assign d3 = d0;
   initial begin
      sel_n = 1;
      sclk = 0;
      d0 = 0;
      rx = 0;
   end
   // One frame: n bits MSB first, link clock still outside it
   task frame(input logic [63:0] v, input int n);
      sel_n = 0;
      #100;
      for (int i = 0; i < n; i++) begin
         d0 = v[63-i];
         #100 sclk = 1;
         #100 rx = {rx[14:0], d1};
         sclk = 0;
      end
      #100 sel_n = 1;
      d0 = ~d0; // Released line loses its value
      #500;
   endtask
endmodule

// ===== tb.sv
// Self-checking bench of the flash command front end
`timescale 1ns/1ps
module tb;
   logic sys_clk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic prog_ready_i = 0, sel_n_i, sclk_i, sin, q1o, q1oe, q2, q3;
   logic [3:0] reg_addr_i = 0;
   logic [31:0] reg_wdata_i = 0, reg_rdata_o;
   logic cmd_valid_o, prog_valid_o;
   logic [7:0] cmd_op_o;
   logic [23:0] cmd_addr_o;
   logic [8:0] prog_data_o;
   int n_fail = 0, n_checks = 0, cyc = 0;
   wire q1 = q1oe ? q1o : sin; // Shared line one
   always #12.5 sys_clk_i = ~sys_clk_i;
   sfcf_host h (.sel_n(sel_n_i), .sclk(sclk_i), .d0(sin), .d2(q2),
      .d3(q3), .d1(q1));
   sfcf_core dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .sel_n_i(sel_n_i), .sclk_i(sclk_i), .serial_in_line_i(sin),
      .quad_line_one_i(q1), .quad_line_one_o(q1o),
      .quad_line_one_oe_o(q1oe), .quad_line_two_i(q2),
      .quad_line_three_i(q3), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .cmd_valid_o(cmd_valid_o),
      .cmd_op_o(cmd_op_o), .cmd_addr_o(cmd_addr_o),
      .prog_data_o(prog_data_o), .prog_valid_o(prog_valid_o),
      .prog_ready_i(prog_ready_i));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1;
      @(posedge sys_clk_i);
      reg_wr_i <= 0;
      @(negedge sys_clk_i);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hffffffff);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1;
      @(posedge sys_clk_i);
      reg_rd_i <= 0;
      @(negedge sys_clk_i);
      chk(reg_rdata_o & m, e);
   endtask
   // Latch set, then the frame itself
   task op(input logic [63:0] v, input int n);
      h.frame({8'h06, 56'h0}, 8);
      h.frame(v, n);
   endtask
   // Let one FIFO word go, then compare the next one shown
   task pull(input logic [8:0] e);
      @(posedge sys_clk_i);
      prog_ready_i <= 1;
      @(posedge sys_clk_i);
      prog_ready_i <= 0;
      @(negedge sys_clk_i);
      chk(prog_data_o, e);
   endtask
   task finish_test;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         finish_test;
      end
   end
   initial begin
      repeat (10) @(posedge sys_clk_i);
      srst_i <= 0;
      rd(4'h0, 0);
      h.frame({16'hffff, 48'h0}, 16);
      h.frame({8'h06, 56'h0}, 8);
      rd(4'h0, 32'h2);
      h.frame({8'h05, 56'h0}, 24);
      chk(h.rx, 16'h0202);
      h.frame({8'h05, 56'h0}, 12);
      h.frame({24'h010040, 40'h0}, 24);
      wr(4'h8, 1);
      rd(4'h0, 32'h4000);
      op({32'h20000000, 32'h0}, 32);
      rd(4'h4, 0);
      wr(4'h8, 1);
      h.frame({8'h50, 56'h0}, 8);
      h.frame({24'h010440, 40'h0}, 24);
      rd(4'h0, 32'h4004);
      op({32'h200ef000, 32'h0}, 32);
      rd(4'h4, 0);
      op({32'h200f0000, 32'h0}, 31);
      rd(4'h4, 0);
      op({32'h200f0000, 32'h0}, 32);
      rd(4'h4, 32'h200f0000);
      h.frame({8'h75, 56'h0}, 8);
      rd(4'h0, 32'h8000, 32'h8000);
      h.frame({8'h7a, 56'h0}, 8);
      rd(4'h0, 0, 32'h8000);
      h.frame({8'h05, 56'h0}, 16);
      chk(h.rx[0], 1);
      h.frame({24'h010000, 40'h0}, 24);
      wr(4'h8, 1);
      rd(4'h0, 32'h4004);
      rd(4'hc, 0);
      op({40'h020f0000a5, 24'h0}, 40);
      rd(4'h4, 32'h020f0000);
      chk(prog_data_o, 9'h0a5);
      pull(9'h101);
      wr(4'h8, 1);
      op({32'h320f0100, 32'h80000000}, 34);
      rd(4'h4, 32'h320f0100);
      pull(9'h0b4);
      pull(9'h101);
      finish_test;
   end
endmodule
